// >>> design/status_hierarchy.sv
// Summary of operation
// - five sixteen-bit parts per status register
// - one source, same bit in all parts
// - bit fifteen always reads zero
// - condition mirrors live inputs or lower sums
// - condition part cannot be written
// - rising edge with filter sets event
// - falling edge with filter sets event
// - edge filters freely read and written
// - event bits stick until read
// - reading event returns value then clears
// - sum is OR of enabled events
// - enable part freely read and written
// - sum feeds next higher condition bit
// - status byte collects three register summaries
// - output buffer drives message available bit
// - masks act as enable parts
// - questionable bit nine is power status
// - request raised on enabled byte rise
// - bit six is master summary, mask ignored
// - status byte bit assignments, bits 0-1 unused
`timescale 1ns/1ps
module status_hierarchy
	import status_pkg::*;
(
	input  wire logic                CLOCK,
	input  wire logic                RESETN,
	input  wire status_pkg::access_type ACCESS,
	input  wire logic [15:0]         OPER_COND,
	input  wire logic [15:0]         QUES_COND,
	input  wire logic                POWER_STATUS,
	input  wire logic [15:0]         STD_EVENT_IN,
	input  wire logic                ERRQ_NONEMPTY,
	input  wire logic                MSG_AVAILABLE,
	output logic [15:0]              RDATA,
	output logic                     RVALID,
	output logic [7:0]               STATUS_BYTE,
	output logic                     SERVICE_REQUEST
);
	logic [15:0] cond_r [4];
	logic [15:0] rise_r [4];
	logic [15:0] fall_r [4];
	logic [15:0] event_r [4];
	logic [15:0] enable_r [4];
	logic [3:0]  sum_r;
	logic [15:0] cond_in [4];
	logic [15:0] rdata_d;
	logic [7:0]  stb_d;
	logic [7:0]  stb_q;
	logic        mss;
	logic [15:0] oper_now;
	logic [15:0] oper_edges;

	// one register part picked by the access word
	function automatic logic selects(input access_type a,
		input logic [1:0] r, input logic [2:0] p);
		return a.reg_sel == r && a.part_sel == p;
	endfunction

	// checker helpers: filtered edges the operation register should see
	assign oper_now = clip(OPER_COND);
	assign oper_edges = (oper_now & ~cond_r[REG_OPER] & rise_r[REG_OPER])
		| (~oper_now & cond_r[REG_OPER] & fall_r[REG_OPER]);

	// power status owns bit nine of questionable
	always_comb
	begin
		cond_in[REG_OPER] = OPER_COND;
		cond_in[REG_QUES] = QUES_COND;
		cond_in[REG_QUES][POWER_BIT] = POWER_STATUS;
		// standard events are pulses seen through rising filters
		cond_in[REG_STD] = STD_EVENT_IN;
		cond_in[REG_STB] = PART_ZERO;
		cond_in[REG_STB][STB_ERRQ] = ERRQ_NONEMPTY;
		cond_in[REG_STB][STB_QUES] = sum_r[REG_QUES];
		cond_in[REG_STB][STB_MSGAV] = MSG_AVAILABLE;
		cond_in[REG_STB][STB_ESUM] = sum_r[REG_STD];
		cond_in[REG_STB][STB_OPER] = sum_r[REG_OPER];
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : regs
			// writes to the condition part are simply not decoded
			status_register u_reg (
				.clock     (CLOCK),
				.resetn    (RESETN),
				.cond_in   (cond_in[g]),
				.wr_rise   (ACCESS.wr
					&& selects(ACCESS, 2'(g), PART_RISE)),
				.wr_fall   (ACCESS.wr
					&& selects(ACCESS, 2'(g), PART_FALL)),
				.wr_enable (ACCESS.wr
					&& selects(ACCESS, 2'(g), PART_ENABLE)),
				.rd_event  (ACCESS.rd
					&& selects(ACCESS, 2'(g), PART_EVENT)),
				.wdata     (ACCESS.wdata),
				.cond_q    (cond_r[g]),
				.rise_q    (rise_r[g]),
				.fall_q    (fall_r[g]),
				.event_q   (event_r[g]),
				.enable_q  (enable_r[g]),
				.sum       (sum_r[g])
			);
		end
	endgenerate

	// master summary excludes bit six of the mask
	assign mss = |(cond_r[REG_STB][7:0] & SRE_MASK
		& enable_r[REG_STB][7:0]);

	always_comb
	begin
		stb_d = cond_r[REG_STB][7:0];
		stb_d[STB_MSS] = mss;
	end

	always_comb
	begin
		rdata_d = PART_ZERO;
		unique case (ACCESS.part_sel)
			PART_COND:   rdata_d = cond_r[ACCESS.reg_sel];
			PART_RISE:   rdata_d = rise_r[ACCESS.reg_sel];
			PART_FALL:   rdata_d = fall_r[ACCESS.reg_sel];
			PART_EVENT:  rdata_d = event_r[ACCESS.reg_sel];
			PART_ENABLE: rdata_d = enable_r[ACCESS.reg_sel];
			default:     rdata_d = PART_ZERO;
		endcase
		if (ACCESS.reg_sel == REG_STB && ACCESS.part_sel == PART_COND)
			rdata_d = {BYTE_ZERO, stb_d};
	end

	always_ff @(posedge CLOCK)
		if (!RESETN)
		begin
			RDATA  <= PART_ZERO;
			RVALID <= 1'b0;
		end
		else
		begin
			RVALID <= ACCESS.rd;
			if (ACCESS.rd)
				RDATA <= clip(rdata_d);
		end

	always_ff @(posedge CLOCK)
		if (!RESETN)
			stb_q <= BYTE_ZERO;
		else
			stb_q <= stb_d;

	always_ff @(posedge CLOCK)
		if (!RESETN)
			STATUS_BYTE <= BYTE_ZERO;
		else
			STATUS_BYTE <= stb_d;

	// request is a pulse on enabled byte bits going 0 to 1
	always_ff @(posedge CLOCK)
		if (!RESETN)
			SERVICE_REQUEST <= 1'b0;
		else
			SERVICE_REQUEST <= |(stb_d & ~stb_q & SRE_MASK
				& enable_r[REG_STB][7:0]);

	srq_rise_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		SERVICE_REQUEST |-> $past(|(stb_d & ~stb_q & SRE_MASK
			& enable_r[REG_STB][7:0])))
		else $error("request without enabled rise");

	srq_edge_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		|(stb_d & ~stb_q & SRE_MASK & enable_r[REG_STB][7:0])
		|=> SERVICE_REQUEST)
		else $error("enabled rise gave no request");

	top_bit_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		RVALID |-> !RDATA[TOP_BIT])
		else $error("bit fifteen read nonzero");

	oper_top_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		((cond_r[REG_OPER] | rise_r[REG_OPER] | fall_r[REG_OPER]
			| event_r[REG_OPER] | enable_r[REG_OPER]) & ~PART_MASK)
			== PART_ZERO)
		else $error("bit fifteen set in a part");

	cond_mirror_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		##1 cond_r[REG_OPER] == clip($past(OPER_COND)))
		else $error("condition not mirroring input");

	power_bit_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		##1 cond_r[REG_QUES][POWER_BIT] == $past(POWER_STATUS))
		else $error("power bit misplaced");

	event_sticky_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		(!(ACCESS.rd && ACCESS.part_sel == PART_EVENT)) |=>
		((event_r[REG_OPER] & $past(event_r[REG_OPER]))
			== $past(event_r[REG_OPER])))
		else $error("event bit lost without read");

	event_grow_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		!(ACCESS.rd && selects(ACCESS, REG_OPER, PART_EVENT))
		|=> event_r[REG_OPER] == ($past(event_r[REG_OPER])
			| $past(oper_edges)))
		else $error("event set without filtered edge");

	event_clear_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		(ACCESS.rd && selects(ACCESS, REG_OPER, PART_EVENT)
			&& oper_now == cond_r[REG_OPER])
		|=> event_r[REG_OPER] == PART_ZERO)
		else $error("event read did not clear");

	event_read_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		ACCESS.rd && selects(ACCESS, REG_OPER, PART_EVENT)
		|=> RVALID && RDATA == $past(event_r[REG_OPER]))
		else $error("event read value wrong");

	read_keep_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		ACCESS.rd && selects(ACCESS, REG_OPER, PART_EVENT)
		|=> event_r[REG_OPER] == $past(oper_edges))
		else $error("new event lost on clearing read");

	rise_set_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		##1 (($past(clip(OPER_COND)) & ~$past(cond_r[REG_OPER])
			& $past(rise_r[REG_OPER])) & ~event_r[REG_OPER]) == PART_ZERO)
		else $error("filtered rise not recorded");

	fall_set_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		##1 ((~$past(clip(OPER_COND)) & $past(cond_r[REG_OPER])
			& $past(fall_r[REG_OPER])) & ~event_r[REG_OPER]) == PART_ZERO)
		else $error("filtered fall not recorded");

	std_quiet_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		rise_r[REG_STD] == PART_ZERO && fall_r[REG_STD] == PART_ZERO
		|=> (event_r[REG_STD] & ~$past(event_r[REG_STD])) == PART_ZERO)
		else $error("unfiltered event recorded");

	rise_write_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		ACCESS.wr && selects(ACCESS, REG_OPER, PART_RISE)
		|=> rise_r[REG_OPER] == clip($past(ACCESS.wdata)))
		else $error("rise filter write lost");

	rise_hold_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		!(ACCESS.wr && selects(ACCESS, REG_OPER, PART_RISE))
		|=> $stable(rise_r[REG_OPER]))
		else $error("rise filter changed unwritten");

	rise_read_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		ACCESS.rd && !ACCESS.wr
			&& selects(ACCESS, REG_OPER, PART_RISE)
		|=> RDATA == $past(rise_r[REG_OPER])
			&& $stable(rise_r[REG_OPER]))
		else $error("rise filter read wrong");

	fall_write_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		ACCESS.wr && selects(ACCESS, REG_OPER, PART_FALL)
		|=> fall_r[REG_OPER] == clip($past(ACCESS.wdata)))
		else $error("fall filter write lost");

	fall_hold_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		!(ACCESS.wr && selects(ACCESS, REG_OPER, PART_FALL))
		|=> $stable(fall_r[REG_OPER]))
		else $error("fall filter changed unwritten");

	enable_write_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		ACCESS.wr && selects(ACCESS, REG_OPER, PART_ENABLE)
		|=> enable_r[REG_OPER] == clip($past(ACCESS.wdata)))
		else $error("enable write lost");

	enable_hold_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		!(ACCESS.wr && selects(ACCESS, REG_OPER, PART_ENABLE))
		|=> $stable(enable_r[REG_OPER]))
		else $error("enable changed unwritten");

	enable_read_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		ACCESS.rd && !ACCESS.wr
			&& selects(ACCESS, REG_OPER, PART_ENABLE)
		|=> RDATA == $past(enable_r[REG_OPER])
			&& $stable(enable_r[REG_OPER]))
		else $error("enable read wrong");

	cond_read_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		ACCESS.rd && selects(ACCESS, REG_OPER, PART_COND)
		|=> RDATA == $past(cond_r[REG_OPER]))
		else $error("condition read wrong");

	ques_sum_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		sum_r[REG_QUES]
			== ((event_r[REG_QUES] & enable_r[REG_QUES]) != PART_ZERO))
		else $error("questionable sum wrong");

	mss_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		##1 STATUS_BYTE[STB_MSS] == $past(mss))
		else $error("master summary wrong");

	sum_up_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		##1 cond_r[REG_STB][STB_OPER] == $past(sum_r[REG_OPER]))
		else $error("sum not propagated");

	ques_up_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		##1 cond_r[REG_STB][STB_QUES] == $past(sum_r[REG_QUES]))
		else $error("questionable sum not propagated");

	esum_up_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		##1 cond_r[REG_STB][STB_ESUM] == $past(sum_r[REG_STD]))
		else $error("event status sum not propagated");

	msgav_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		##1 cond_r[REG_STB][STB_MSGAV] == $past(MSG_AVAILABLE))
		else $error("message available bit wrong");

	errq_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		##1 cond_r[REG_STB][STB_ERRQ] == $past(ERRQ_NONEMPTY))
		else $error("error queue bit wrong");

	byte_follow_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		##1 STATUS_BYTE == $past(stb_d) && STATUS_BYTE[1:0] == 2'b00)
		else $error("status byte wrong");

	reset_clear_a: assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		$rose(RESETN) |-> event_r[REG_OPER] == PART_ZERO
			&& enable_r[REG_OPER] == PART_ZERO)
		else $error("reset left event or enable set");
endmodule

// >>> design/status_pkg.sv
package status_pkg;
	localparam int PART_WIDTH = 16;
	localparam int TOP_BIT = 15;
	localparam int POWER_BIT = 9;
	localparam logic [15:0] PART_MASK = 16'h7fff;
	localparam logic [15:0] PART_ZERO = 16'h0000;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// status byte bit positions
	localparam int STB_ERRQ = 2;
	localparam int STB_QUES = 3;
	localparam int STB_MSGAV = 4;
	localparam int STB_ESUM = 5;
	localparam int STB_MSS = 6;
	localparam int STB_OPER = 7;
	localparam logic [7:0] SRE_MASK = 8'hbc;

	// register select codes
	localparam logic [1:0] REG_OPER = 2'h0;
	localparam logic [1:0] REG_QUES = 2'h1;
	localparam logic [1:0] REG_STD = 2'h2;
	localparam logic [1:0] REG_STB = 2'h3;

	// part select codes
	localparam logic [2:0] PART_COND = 3'h0;
	localparam logic [2:0] PART_RISE = 3'h1;
	localparam logic [2:0] PART_FALL = 3'h2;
	localparam logic [2:0] PART_EVENT = 3'h3;
	localparam logic [2:0] PART_ENABLE = 3'h4;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [1:0]  reg_sel;
		logic [2:0]  part_sel;
		logic [15:0] wdata;
	} access_type;

	function automatic logic [15:0] clip(input logic [15:0] v);
		return v & PART_MASK;
	endfunction
endpackage

// >>> design/status_register.sv
`timescale 1ns/1ps
module status_register
	import status_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic [15:0] cond_in,
	input  wire logic        wr_rise,
	input  wire logic        wr_fall,
	input  wire logic        wr_enable,
	input  wire logic        rd_event,
	input  wire logic [15:0] wdata,
	output logic [15:0]      cond_q,
	output logic [15:0]      rise_q,
	output logic [15:0]      fall_q,
	output logic [15:0]      event_q,
	output logic [15:0]      enable_q,
	output logic             sum
);
	logic [15:0] hit;

	always_ff @(posedge clock)
		cond_q <= clip(cond_in);

	assign hit = ((cond_q & ~clip(cond_in)) == PART_ZERO ? PART_ZERO :
		(cond_q & ~clip(cond_in) & fall_q))
		| (~cond_q & clip(cond_in) & rise_q);

	always_ff @(posedge clock)
		if (!resetn)
			rise_q <= PART_ZERO;
		else if (wr_rise)
			rise_q <= clip(wdata);

	always_ff @(posedge clock)
		if (!resetn)
			fall_q <= PART_ZERO;
		else if (wr_fall)
			fall_q <= clip(wdata);

	always_ff @(posedge clock)
		if (!resetn)
			enable_q <= PART_ZERO;
		else if (wr_enable)
			enable_q <= clip(wdata);

	always_ff @(posedge clock)
		if (!resetn)
			event_q <= PART_ZERO;
		else if (rd_event)
			event_q <= clip(hit);
		else
			event_q <= clip(event_q | hit);

	assign sum = |(event_q & enable_q);
endmodule

// >>> dv/remote_ctrl.sv
`timescale 1ns/1ps
module remote_ctrl
(
	input  wire logic               clock,
	input  wire logic               rvalid,
	input  wire logic [15:0]        rdata,
	output status_pkg::access_type  access
);
	import status_pkg::*;
	initial access = '0;
	task automatic wr(input logic [1:0] r, input logic [2:0] p,
		input logic [15:0] d);
		@(negedge clock);
		access <= '{1'b0, 1'b1, r, p, d};
		@(negedge clock);
		access <= '0;
	endtask
	// a read that never answers hands back x, which no compare accepts
	task automatic rd(input logic [1:0] r, input logic [2:0] p,
		output logic [15:0] d);
		int n;
		d = 'x;
		@(negedge clock);
		access <= '{1'b1, 1'b0, r, p, 16'h0000};
		@(negedge clock);
		access <= '0;
		for (n = 0; n < 4 && rvalid !== 1'b1; n++)
			@(negedge clock);
		if (rvalid === 1'b1)
			d = rdata;
	endtask
endmodule

// >>> dv/tb_scpi_status_register_hierarchy.sv
`timescale 1ns/1ps
`define CHK(n, e, s) check_count++; if ((s) !== (e)) begin fails++; \
$display("Error %s exp %h got %h", n, e, s); end
module tb_scpi_status_register_hierarchy;
	import status_pkg::*;
	logic        clock = 0;
	logic        resetn = 0;
	access_type  acc;
	logic [15:0] oper = 0, ques = 0, stde = 0, rdata, rd_d;
	logic        pwr = 0, errq = 0, mav = 0, rvalid, srq;
	logic [7:0]  stb;
	logic [15:0] rise_m, fall_m, ev_m;
	int          fails = 0, check_count = 0, srq_n = 0, p;
	always #4 clock = ~clock;
	always @(posedge clock)
		if (srq === 1'b1)
			srq_n <= srq_n + 1;
	status_hierarchy uut (.CLOCK(clock), .RESETN(resetn),
		.ACCESS(acc), .OPER_COND(oper), .QUES_COND(ques),
		.POWER_STATUS(pwr), .STD_EVENT_IN(stde),
		.ERRQ_NONEMPTY(errq), .MSG_AVAILABLE(mav), .RDATA(rdata),
		.RVALID(rvalid), .STATUS_BYTE(stb), .SERVICE_REQUEST(srq));
	remote_ctrl host (.clock(clock), .rvalid(rvalid), .rdata(rdata),
		.access(acc));
	task automatic report_and_stop;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chkrd(input int r, input int p, input logic [15:0] e);
		host.rd(r[1:0], p[2:0], rd_d);
		`CHK("rdata", e, rd_d)
	endtask
	// the model tracks only the operation register's edge filters
	task automatic set_oper(input logic [15:0] v);
		logic [15:0] o, n;
		o = oper & PART_MASK;
		n = v & PART_MASK;
		ev_m |= (rise_m & n & ~o) | (fall_m & o & ~n);
		@(negedge clock);
		oper = v;
		repeat (3) @(negedge clock);
	endtask
	initial
	begin
		#200000;
		fails++;
		report_and_stop();
	end
	initial
	begin
		void'($urandom(32'h689ce4de));
		ques = $urandom;
		stde = $urandom;
		ev_m = 0;
		repeat (12) @(negedge clock);
		resetn = 1;
		for (p = 1; p < 5; p++)
			chkrd(0, p, 16'h0000);
		chkrd(0, 0, 16'h0000);
		for (p = 1; p < 5; p++)
			if (p != 3)
			begin
				rd_d = $urandom;
				host.wr(2'h1, p[2:0], rd_d);
				chkrd(1, p, rd_d & PART_MASK);
				chkrd(1, p, rd_d & PART_MASK);
			end
		host.wr(REG_OPER, PART_COND, 16'h1234);
		chkrd(0, 0, 16'h0000);
		rise_m = $urandom & PART_MASK;
		fall_m = $urandom & PART_MASK;
		host.wr(REG_OPER, PART_RISE, rise_m);
		host.wr(REG_OPER, PART_FALL, fall_m);
		repeat (4)
		begin
			set_oper($urandom);
			set_oper($urandom);
			chkrd(0, 0, oper & PART_MASK);
			chkrd(0, 3, ev_m);
			ev_m = 0;
			chkrd(0, 3, 16'h0000);
		end
		srq_n = 0;
		rise_m = PART_MASK;
		host.wr(REG_STB, PART_ENABLE, 16'h0080);
		host.wr(REG_OPER, PART_RISE, rise_m);
		host.wr(REG_OPER, PART_ENABLE, 16'h0001);
		set_oper(oper & 16'hfffe);
		set_oper(oper | 16'h0001);
		`CHK("stb", 8'hc0, stb & 8'hfc)
		// the request pulse is counted one edge after it stands
		@(negedge clock);
		`CHK("srq", 1, srq_n)
		chkrd(3, 0, 16'h00c0);
		chkrd(0, 3, ev_m);
		repeat (3) @(negedge clock);
		`CHK("stb", 8'h00, stb)
		mav = 1;
		errq = 1;
		repeat (3) @(negedge clock);
		`CHK("stb", 8'h14, stb)
		pwr = 1;
		repeat (3) @(negedge clock);
		chkrd(1, 0, (ques & 16'h7dff) | 16'h0200);
		report_and_stop();
	end
endmodule
